// >>> dv/pmic_host_model.sv
// Host-side stand-in for the sequencer: report-pin pull-ups and serial command pulses.
// Assumes the sequencer drives its report pins open-drain and shares the bench clock.
`timescale 1ns/10ps
`default_nettype none

module pmic_host_model (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Pin drive from the sequencer.
   input wire pmic_seq_pkg::report_t i_oe,
   // Command requests from the bench, as levels.
   input wire logic i_req_latch_clear,
   input wire logic i_req_status_clear,
   // Pin levels and command pulses.
   output pmic_seq_pkg::report_t o_pin,
   output logic o_latch_clear,
   output pmic_seq_pkg::fault_t o_status_clear
);
   logic lc_reg;
   logic sc_reg;

   // Every report pin has a pull-up, so a released pin reads high, never its last level.
   assign o_pin = ~i_oe;

   // A request edge becomes a single one-cycle command, as one serial frame would give.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lc_reg <= 1'b0;
         sc_reg <= 1'b0;
         o_latch_clear <= 1'b0;
         o_status_clear <= pmic_seq_pkg::FAULT_NONE;
      end else begin
         lc_reg <= i_req_latch_clear;
         sc_reg <= i_req_status_clear;
         o_latch_clear <= i_req_latch_clear & ~lc_reg;
         o_status_clear <= {pmic_seq_pkg::FAULT_W{i_req_status_clear & ~sc_reg}};
      end
   end
endmodule

`default_nettype wire

// >>> dv/tb_pmic_fault_response_sequencer.sv
// Self-checking bench for the power and fault sequencer with a host stand-in.
// Assumes short pulse and deglitch counts; fault cases run as table rows.
`timescale 1ns/10ps
`default_nettype none

module tb_pmic_fault_response_sequencer;
   localparam int P = 20;
   localparam int D = 8;
   `define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
      $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
   typedef struct packed {
      pmic_seq_pkg::fault_t f;
      pmic_seq_pkg::cfg_t c;
      logic [6:0] e;
      pmic_seq_pkg::fault_t s;
   } row_t;
   logic clk, rst_b, up_ok, lo_trip, a19, b18, req_lc, req_sc, lclr, seen;
   logic prereg, ldo, aon, fh, wden, mism;
   logic [2:0] en;
   logic [1:0] latch;
   logic [1:0] lset;
   pmic_seq_pkg::fault_t flt, stat, sclr;
   pmic_seq_pkg::cfg_t cfg;
   pmic_seq_pkg::report_t oe, drv, pin;
   pmic_seq_pkg::pwr_state_t st;
   int num_errors, checked, n;
   // Fault, config, expected {ff, rst, safe, wdf, prereg, ldo, watchdog}, expected status.
   row_t rows [19] = '{{15'h4000, 7'h00, 7'h47, 15'h4000}, {15'h4000, 7'h40, 7'h76, 15'h4000},
      {15'h2000, 7'h20, 7'h76, 15'h2000}, {15'h1000, 7'h10, 7'h76, 15'h1000},
      {15'h0800, 7'h08, 7'h76, 15'h0800}, {15'h2000, 7'h00, 7'h47, 15'h2000},
      {15'h0400, 7'h00, 7'h1F, 15'h0400}, {15'h0400, 7'h01, 7'h5F, 15'h0400},
      {15'h0200, 7'h00, 7'h47, 15'h0200}, {15'h0100, 7'h00, 7'h50, 15'h0100},
      {15'h0100, 7'h02, 7'h47, 15'h0200}, {15'h0080, 7'h00, 7'h57, 15'h0080},
      {15'h0040, 7'h00, 7'h57, 15'h0040}, {15'h0020, 7'h00, 7'h57, 15'h0020},
      {15'h0010, 7'h00, 7'h57, 15'h0010}, {15'h0008, 7'h00, 7'h70, 15'h0008},
      {15'h0004, 7'h00, 7'h53, 15'h0004}, {15'h0002, 7'h00, 7'h47, 15'h0002},
      {15'h0001, 7'h00, 7'h57, 15'h0001}};

   // The host's latch-set command is driven straight from the bench as a one-cycle pulse.
   pmic_fault_response_sequencer #(.RST_PULSE_CYC(P), .DEGLITCH_CYC(D)) i_dut (
      .i_clk(clk), .i_rst_b(rst_b), .i_enable_inputs(en), .i_input_lockout_upper_ok(up_ok),
      .i_input_lockout_lower_trip(lo_trip), .i_input_above_19v(a19), .i_input_below_18v(b18),
      .i_faults(flt), .i_report_di(pin), .i_cfg(cfg), .i_latch_set(lset),
      .i_latch_clear(lclr), .i_status_clear(sclr), .o_report_do(drv), .o_report_oe(oe),
      .o_prereg_on(prereg), .o_ldo_on(ldo), .o_always_on_ldo_from_input(aon),
      .o_freq_half(fh), .o_watchdog_en(wden), .o_status(stat), .o_enable_latch(latch),
      .o_state(st), .o_pin_mismatch(mism));
   pmic_host_model i_host (.i_clk(clk), .i_rst_b(rst_b), .i_oe(oe),
      .i_req_latch_clear(req_lc), .i_req_status_clear(req_sc), .o_pin(pin),
      .o_latch_clear(lclr), .o_status_clear(sclr));

   // Free-running 250 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // Waits, bounded, for the state (w = 0) or the reset pin drive (w = 1) to reach v.
   task automatic wt(input int w, input logic [1:0] v, output int k);
      k = 0;
      while ((w ? {1'b0, oe.rst} : st) !== v && k < 300) begin
         cyc(1);
         k++;
      end
      if (k >= 300) begin
         num_errors++;
         $display("ERROR wait expected %0h seen %0h", v, w ? {1'b0, oe.rst} : st);
         results();
      end
   endtask

   // The host clears all sticky status bits, then the flag is given time to settle.
   task automatic clr();
      @(posedge clk);
      req_sc <= 1'b1;
      @(posedge clk);
      req_sc <= 1'b0;
      cyc(6);
   endtask

   // Main sequence: reset, power-up, fault table, then the awkward cases.
   initial begin
      {rst_b, up_ok, lo_trip, a19, req_lc, req_sc, en, lset} = '0;
      b18 = 1'b1;
      flt = pmic_seq_pkg::FAULT_NONE;
      cfg = '0;
      num_errors = 0;
      checked = 0;
      cyc(20);
      `CHK("reset", {4'h0, 1'b1, pmic_seq_pkg::ST_OFF}, {oe, aon, st});
      @(posedge clk);
      rst_b <= 1'b1;
      up_ok <= 1'b1;
      en <= 3'b100;
      wt(0, pmic_seq_pkg::ST_PWRUP, n);
      @(posedge clk);
      en <= 3'b000;
      seen = 1'b0;
      repeat (D + 4) begin
         cyc(1);
         if (st === pmic_seq_pkg::ST_ON) seen = 1'b1;
      end
      `CHK("abort", {1'b0, pmic_seq_pkg::ST_OFF}, {seen, st});
      @(posedge clk);
      en <= 3'b011;
      wt(0, pmic_seq_pkg::ST_ON, n);
      `CHK("latch", 2'b11, latch);
      cyc(3);
      `CHK("run", 4'b0111, {oe.rst, prereg, ldo, wden});
      for (int i = 0; i < 19; i++) begin
         @(posedge clk);
         cfg <= rows[i].c;
         flt <= rows[i].f;
         cyc(8);
         `CHK("pins", rows[i].e[6:3], oe);
         `CHK("regs", rows[i].e[2:0], {prereg, ldo, wden});
         `CHK("aon", |rows[i].f[3:2], aon);
         `CHK("status", rows[i].s, stat);
         @(posedge clk);
         flt <= pmic_seq_pkg::FAULT_NONE;
         cyc(6);
         `CHK("flag_held", rows[i].e[6], oe.ff);
         clr();
         `CHK("flag_free", 1'b0, oe.ff);
      end
      `CHK("readback", 5'h00, {drv, mism});
      // The reset pulse is a one-shot: it ends while the watchdog fault is still present.
      @(posedge clk);
      cfg <= 7'h04;
      flt <= 15'h0400;
      wt(1, 2'b01, n);
      wt(1, 2'b00, n);
      `CHK("pulse_len", 1'b1, (n >= P - 1 && n <= P + 1));
      `CHK("wd_pin", 1'b1, oe.wdf);
      @(posedge clk);
      flt <= pmic_seq_pkg::FAULT_NONE;
      b18 <= 1'b0;
      a19 <= 1'b1;
      clr();
      `CHK("freq_half", 1'b1, fh);
      @(posedge clk);
      a19 <= 1'b0;
      cyc(6);
      `CHK("freq_hyst", 1'b1, fh);
      @(posedge clk);
      b18 <= 1'b1;
      en <= 3'b000;
      cyc(10);
      `CHK("freq_back", {1'b0, pmic_seq_pkg::ST_ON}, {fh, st});
      @(posedge clk);
      req_lc <= 1'b1;
      wt(0, pmic_seq_pkg::ST_OFF, n);
      `CHK("latch_clr", 2'b00, latch);
      @(posedge clk);
      req_lc <= 1'b0;
      en <= 3'b001;
      wt(0, pmic_seq_pkg::ST_ON, n);
      @(posedge clk);
      en <= 3'b000;
      cfg <= 7'h40;
      flt <= 15'h4000;
      wt(0, pmic_seq_pkg::ST_OFF, n);
      `CHK("latch_fault", 2'b00, latch);
      @(posedge clk);
      flt <= pmic_seq_pkg::FAULT_NONE;
      en <= 3'b100;
      wt(0, pmic_seq_pkg::ST_ON, n);
      `CHK("no_latch", 2'b00, latch);
      // The logic enable has no latch, so only the host's set command can hold the device up.
      @(posedge clk);
      lset <= 2'b10;
      @(posedge clk);
      lset <= 2'b00;
      en <= 3'b000;
      cyc(10);
      `CHK("latch_set", {2'b10, pmic_seq_pkg::ST_ON}, {latch, st});
      @(posedge clk);
      lo_trip <= 1'b1;
      wt(0, pmic_seq_pkg::ST_OFF, n);
      cyc(6);
      `CHK("lockout", pmic_seq_pkg::ST_OFF, st);
      // A reset in mid-run must drop everything at once and allow a clean restart.
      @(posedge clk);
      lo_trip <= 1'b0;
      en <= 3'b001;
      rst_b <= 1'b0;
      cyc(2);
      `CHK("reset_mid", {4'h0, 1'b1, pmic_seq_pkg::ST_OFF}, {oe, aon, st});
      @(posedge clk);
      rst_b <= 1'b1;
      cyc(2);
      `CHK("release", {4'h4, pmic_seq_pkg::ST_OFF}, {oe, st});
      wt(0, pmic_seq_pkg::ST_ON, n);
      results();
   end
endmodule

`default_nettype wire

// >>> inc/pmic_seq_pkg.sv
// Constants, field layouts and state codes of the power and fault sequencer.
// Assumes a single 250 MHz controller clock shared with the serial-port logic.
package pmic_seq_pkg;
   // Clock period and time figures; the cycle counts are derived from them.
   localparam int CLK_PERIOD_PS = 4000;
   localparam int DEGLITCH_NS = 1000;
   localparam int DEGLITCH_CYC = (DEGLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RST_PULSE_MS = 2;
   localparam int RST_PULSE_CYC = (RST_PULSE_MS * 1000000000) / CLK_PERIOD_PS;
   // Pin counts and counter width.
   localparam int N_EN = 3;
   localparam int N_LATCH = 2;
   localparam int N_CNT = 20;

   // Power states.
   typedef enum logic [1:0] {
      ST_OFF = 2'h0,
      ST_PWRUP = 2'h1,
      ST_ON = 2'h2
   } pwr_state_t;

   // One bit per fault source; also the layout of the sticky status word.
   typedef struct packed {
      logic aux_uv;
      logic in_ov;
      logic mcu_ov;
      logic aux_ov;
      logic wdog;
      logic twarn;
      logic thermal_shutdown;
      logic analog_self_test;
      logic logic_self_test;
      logic nvm;
      logic logic_err;
      logic clk_stuck;
      logic pwm_stuck;
      logic cs_tmo;
      logic clk_range;
   } fault_t;

   // Serial-port programmed report selects and options.
   typedef struct packed {
      logic rpt_aux_uv;
      logic rpt_in_ov;
      logic rpt_mcu_ov;
      logic rpt_aux_ov;
      logic rpt_wdog;
      logic thermal_shutdown_mask;
      logic wd_ff_en;
   } cfg_t;

   // The four open-drain report pins.
   typedef struct packed {
      logic ff;
      logic rst;
      logic safe;
      logic wdf;
   } report_t;

   localparam int FAULT_W = $bits(fault_t);
   localparam int REPORT_W = $bits(report_t);
   localparam fault_t FAULT_NONE = fault_t'(15'h0000);
   localparam report_t REPORT_NONE = report_t'(4'h0);
endpackage

// >>> rtl/pmic_fault_response_sequencer.sv
// Power-up and power-down sequencing plus fault-to-pin mapping of the supervisor.
// Assumes the serial-port logic on the same clock supplies configuration levels
// and one-cycle command pulses; analog comparators and fault detectors are async.
//
// Contract
// - Any enable with supply ok starts power-up.
// - Enable lost during deglitch returns to off.
// - Enable latch keeps device on without enables.
// - Reset fault while latched clears latches, powers down.
// - Power-down needs enables low and latch clear, unless lower lockout trips.
// - Supply below lower lockout always powers down.
// - Frequency halves above 19 V, restores below 18 V.
// - Aux LDO undervoltage flags; selects reset, safe.
// - Overvoltages flag; selected ones reset, safe, stop.
// - Watchdog fault: safe, wd pin, optional reset pulse.
// - Watchdog sets fault flag only when enabled.
// - Thermal shutdown stops regulators unless masked.
// - Thermal warning flags until host clears it.
// - Analog self-test failure flags and drives safe.
// - Logic, memory, internal errors flag and drive safe.
// - Stuck controller clock kills regulators and resets.
// - Stuck switching clock kills preregulator, drives safe.
// - Chip-select timeout only flags the host.
// - Clock out of range flags and drives safe.
`timescale 1ns/10ps
`default_nettype none

module pmic_fault_response_sequencer #(
   parameter int RST_PULSE_CYC = pmic_seq_pkg::RST_PULSE_CYC,
   parameter int DEGLITCH_CYC = pmic_seq_pkg::DEGLITCH_CYC
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Asynchronous pins and comparators.
   input wire logic [pmic_seq_pkg::N_EN-1:0] i_enable_inputs,
   input wire logic i_input_lockout_upper_ok,
   input wire logic i_input_lockout_lower_trip,
   input wire logic i_input_above_19v,
   input wire logic i_input_below_18v,
   input wire pmic_seq_pkg::fault_t i_faults,
   input wire pmic_seq_pkg::report_t i_report_di,
   // Serial-port configuration and commands, same clock.
   input wire pmic_seq_pkg::cfg_t i_cfg,
   input wire logic [pmic_seq_pkg::N_LATCH-1:0] i_latch_set,
   input wire logic i_latch_clear,
   input wire pmic_seq_pkg::fault_t i_status_clear,
   // Open-drain report pins.
   output pmic_seq_pkg::report_t o_report_do,
   output pmic_seq_pkg::report_t o_report_oe,
   // Regulator and watchdog control.
   output logic o_prereg_on,
   output logic o_ldo_on,
   output logic o_always_on_ldo_from_input,
   output logic o_freq_half,
   output logic o_watchdog_en,
   // Status towards the serial port.
   output pmic_seq_pkg::fault_t o_status,
   output logic [pmic_seq_pkg::N_LATCH-1:0] o_enable_latch,
   output pmic_seq_pkg::pwr_state_t o_state,
   output logic o_pin_mismatch
);
   localparam int SYNC_W = pmic_seq_pkg::N_EN + 4 + pmic_seq_pkg::FAULT_W
                           + pmic_seq_pkg::REPORT_W;
   localparam int CW = pmic_seq_pkg::N_CNT;

   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic [pmic_seq_pkg::N_EN-1:0] en_s;
   logic lockout_ok_s, lockout_trip_s, above19_s, below18_s;
   pmic_seq_pkg::fault_t live;
   pmic_seq_pkg::report_t pin_s;
   pmic_seq_pkg::pwr_state_t state_reg, state_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic [CW-1:0] rst_cnt_reg, rst_cnt_next;
   logic [pmic_seq_pkg::N_LATCH-1:0] latch_reg, latch_next;
   pmic_seq_pkg::fault_t status_reg, status_next, status_set, ff_mask;
   logic wd_prev_reg;
   pmic_seq_pkg::report_t oe_next;
   pmic_seq_pkg::report_t oe_d1_reg, oe_d2_reg;
   logic freq_half_reg, freq_half_next;

   // Two flip-flops on every asynchronous input before any logic looks at it.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {i_enable_inputs, i_input_lockout_upper_ok, i_input_lockout_lower_trip,
                       i_input_above_19v, i_input_below_18v, i_faults, i_report_di};
         sync2_reg <= sync1_reg;
      end
   end

   assign {en_s, lockout_ok_s, lockout_trip_s, above19_s, below18_s, live, pin_s} = sync2_reg;

   // Fault decoding shared by the pins, the regulators and the sequencer.
   wire any_en = |en_s;
   wire is_on = (state_reg == pmic_seq_pkg::ST_ON);
   wire thermal_kill = live.thermal_shutdown & ~i_cfg.thermal_shutdown_mask;
   wire ovuv_sel = (live.aux_uv & i_cfg.rpt_aux_uv)
                 | (live.in_ov & i_cfg.rpt_in_ov)
                 | (live.mcu_ov & i_cfg.rpt_mcu_ov)
                 | (live.aux_ov & i_cfg.rpt_aux_ov);
   wire rst_fault = ovuv_sel | live.clk_stuck;
   wire wd_rise = live.wdog & ~wd_prev_reg;
   wire wd_pulse = (rst_cnt_reg != '0);
   wire deglitch_done = (cnt_reg == CW'(DEGLITCH_CYC - 1));
   wire latched_only = ~any_en & (latch_reg != '0);

   // Sticky status: a fault present in the clearing cycle stays set.
   always_comb begin
      status_set = live;
      status_set.thermal_shutdown = thermal_kill;
      status_set.twarn = live.twarn
                       | (live.thermal_shutdown & i_cfg.thermal_shutdown_mask);
      status_next = (status_reg & ~i_status_clear) | status_set;
      ff_mask = ~pmic_seq_pkg::FAULT_NONE;
      ff_mask.wdog = i_cfg.wd_ff_en;
   end

   // Pin demands; a set enable bit pulls the pin low.
   always_comb begin
      oe_next = pmic_seq_pkg::REPORT_NONE;
      oe_next.ff = is_on & |(status_reg & ff_mask);
      oe_next.rst = ~is_on | rst_fault | wd_pulse;
      oe_next.safe = is_on & (ovuv_sel | live.wdog | thermal_kill
                   | status_reg.analog_self_test | status_reg.logic_self_test
                   | status_reg.nvm | status_reg.logic_err
                   | live.clk_stuck | live.pwm_stuck | live.clk_range);
      oe_next.wdf = is_on & live.wdog;
   end

   // Switching frequency hysteresis between the two input thresholds.
   always_comb begin
      freq_half_next = freq_half_reg;
      if (above19_s) begin
         freq_half_next = 1'b1;
      end else if (below18_s) begin
         freq_half_next = 1'b0;
      end
   end

   // Watchdog reset one-shot, started on a new watchdog fault when selected.
   always_comb begin
      rst_cnt_next = rst_cnt_reg;
      if (wd_rise & i_cfg.rpt_wdog & is_on) begin
         rst_cnt_next = CW'(RST_PULSE_CYC);
      end else if (wd_pulse) begin
         rst_cnt_next = rst_cnt_reg - 1'b1;
      end
   end

   // Power sequencer. The lower lockout overrides every state.
   always_comb begin
      state_next = state_reg;
      cnt_next = '0;
      latch_next = latch_reg;
      unique case (state_reg)
         pmic_seq_pkg::ST_OFF: begin
            latch_next = '0;
            if (any_en & lockout_ok_s) begin
               state_next = pmic_seq_pkg::ST_PWRUP;
            end
         end
         pmic_seq_pkg::ST_PWRUP: begin
            if (!any_en) begin
               state_next = pmic_seq_pkg::ST_OFF;
            end else if (deglitch_done) begin
               state_next = pmic_seq_pkg::ST_ON;
               latch_next = en_s[pmic_seq_pkg::N_LATCH-1:0];
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         pmic_seq_pkg::ST_ON: begin
            // A set request in the same cycle as a clear keeps the bits it sets; the other latch bits clear.
            latch_next = (i_latch_clear ? '0 : latch_reg) | i_latch_set;
            if (latched_only & rst_fault) begin
               latch_next = '0;
               state_next = pmic_seq_pkg::ST_OFF;
            end else if (!any_en & (latch_next == '0)) begin
               state_next = pmic_seq_pkg::ST_OFF;
            end
         end
         default: begin
            state_next = pmic_seq_pkg::ST_OFF;
         end
      endcase
      if (lockout_trip_s) begin
         state_next = pmic_seq_pkg::ST_OFF;
         latch_next = '0;
      end
   end

   // State, counters and latches.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= pmic_seq_pkg::ST_OFF;
         cnt_reg <= '0;
         rst_cnt_reg <= '0;
         latch_reg <= '0;
         wd_prev_reg <= 1'b0;
         freq_half_reg <= 1'b0;
         status_reg <= pmic_seq_pkg::FAULT_NONE;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         rst_cnt_reg <= rst_cnt_next;
         latch_reg <= latch_next;
         wd_prev_reg <= live.wdog;
         freq_half_reg <= freq_half_next;
         status_reg <= status_next;
      end
   end

   // Registered outputs. The serial port keeps running through thermal shutdown.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_report_do <= pmic_seq_pkg::REPORT_NONE;
         o_report_oe <= pmic_seq_pkg::REPORT_NONE;
         o_prereg_on <= 1'b0;
         o_ldo_on <= 1'b0;
         o_always_on_ldo_from_input <= 1'b1;
         o_watchdog_en <= 1'b0;
         o_pin_mismatch <= 1'b0;
         oe_d1_reg <= pmic_seq_pkg::REPORT_NONE;
         oe_d2_reg <= pmic_seq_pkg::REPORT_NONE;
      end else begin
         o_report_do <= pmic_seq_pkg::REPORT_NONE;
         o_report_oe <= oe_next;
         o_prereg_on <= is_on & ~thermal_kill & ~live.clk_stuck & ~live.pwm_stuck;
         o_ldo_on <= is_on & ~thermal_kill & ~live.clk_stuck;
         o_always_on_ldo_from_input <= ~is_on | live.clk_stuck | live.pwm_stuck;
         o_watchdog_en <= is_on & ~ovuv_sel & ~thermal_kill & ~live.clk_stuck;
         oe_d1_reg <= o_report_oe;
         oe_d2_reg <= oe_d1_reg; // Lines the demand up with the two-stage readback.
         o_pin_mismatch <= |(oe_d2_reg & pin_s);
      end
   end

   assign o_freq_half = freq_half_reg;
   assign o_status = status_reg;
   assign o_enable_latch = latch_reg;
   assign o_state = state_reg;

   // Checks on the sequencer and the fault mapping.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   property p_start;
      state_reg == pmic_seq_pkg::ST_OFF && any_en && lockout_ok_s && !lockout_trip_s
         |=> state_reg == pmic_seq_pkg::ST_PWRUP;
   endproperty
   a_start: assert property (p_start) else $error("Power-up did not start.");
   property p_glitch;
      state_reg == pmic_seq_pkg::ST_PWRUP && !any_en |=> state_reg == pmic_seq_pkg::ST_OFF;
   endproperty
   a_glitch: assert property (p_glitch) else $error("Glitched enable not rejected.");
   property p_hold;
      is_on && latched_only && !rst_fault && !i_latch_clear && !lockout_trip_s |=> is_on;
   endproperty
   a_hold: assert property (p_hold) else $error("Latched device powered down.");
   property p_latch_fault;
      is_on && latched_only && rst_fault |=> state_reg == pmic_seq_pkg::ST_OFF && latch_reg == '0;
   endproperty
   a_latch_fault: assert property (p_latch_fault) else $error("Reset fault kept latch.");
   property p_down;
      is_on ##1 !is_on |-> !$past(any_en) || $past(lockout_trip_s);
   endproperty
   a_down: assert property (p_down) else $error("Power-down with enable high.");
   property p_lockout;
      lockout_trip_s |=> state_reg == pmic_seq_pkg::ST_OFF && latch_reg == '0;
   endproperty
   a_lockout: assert property (p_lockout) else $error("Lockout did not power down.");
   property p_freq;
      above19_s |=> freq_half_reg ##1 (freq_half_reg || $past(below18_s));
   endproperty
   a_freq: assert property (p_freq) else $error("Frequency select wrong.");
   property p_aux_uv;
      is_on && live.aux_uv && i_cfg.rpt_aux_uv |=> o_report_oe.rst && o_report_oe.safe;
   endproperty
   a_aux_uv: assert property (p_aux_uv) else $error("Aux undervoltage not reported.");
   property p_wd_pulse;
      is_on && wd_rise && i_cfg.rpt_wdog |=> ##1 o_report_oe.rst [*8];
   endproperty
   a_wd_pulse: assert property (p_wd_pulse) else $error("Watchdog reset pulse short.");
   property p_thermal;
      live.thermal_shutdown && !i_cfg.thermal_shutdown_mask |=> !o_prereg_on && !o_ldo_on;
   endproperty
   a_thermal: assert property (p_thermal) else $error("Thermal shutdown left regulators on.");
   property p_clk_stuck;
      live.clk_stuck |=> o_report_oe.rst && !o_prereg_on && o_always_on_ldo_from_input;
   endproperty
   a_clk_stuck: assert property (p_clk_stuck) else $error("Stuck clock not handled.");
   property p_sticky;
      live.cs_tmo |=> status_reg.cs_tmo;
   endproperty
   a_sticky: assert property (p_sticky) else $error("Fault status lost.");

   c_power_on: cover property (state_reg == pmic_seq_pkg::ST_PWRUP ##1 is_on);
   c_latched: cover property (is_on && latched_only && rst_fault);
   c_wd_pulse: cover property (wd_rise && i_cfg.rpt_wdog && is_on);
   c_clear_race: cover property (|(i_status_clear & status_set));
endmodule

`default_nettype wire
